// *** hdl/mac_flow_pkg.sv ***
// Constants shared by the pause and flow-control logic
package mac_flow_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [3:0]  PHY_DATA_IDX   = 4'h7;
  localparam logic [3:0]  FLOW_IDX       = 4'h8;
  localparam logic [31:0] PHY_DATA_RESET = 32'h00000000;
  localparam logic [31:0] FLOW_RESET     = 32'h00000000;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int PHY_DATA_W    = 16;
  localparam int PAUSE_TIME_W  = 16;
  localparam int FLOW_PT_LSB   = 16;
  localparam int FLOW_PASS_BIT = 2;
  localparam int FLOW_EN_BIT   = 1;
  localparam int FLOW_BUSY_BIT = 0;

  // ****************************************
  // Pause quantum timing
  // ****************************************
  localparam int QUANTUM_BITS  = 512;
  localparam int BIT_NS_FAST   = 10;
  localparam int BIT_NS_SLOW   = 100;
  localparam int CLK_NS        = 25;
  localparam int QCYC_W        = 12;
  localparam logic [QCYC_W-1:0] QUANTUM_CYC_FAST =
    QCYC_W'((QUANTUM_BITS * BIT_NS_FAST + CLK_NS - 1) / CLK_NS);
  localparam logic [QCYC_W-1:0] QUANTUM_CYC_SLOW =
    QCYC_W'((QUANTUM_BITS * BIT_NS_SLOW + CLK_NS - 1) / CLK_NS);

  // ****************************************
  // Transmit side states
  // ****************************************
  typedef enum logic [1:0] {
    FC_IDLE  = 2'b00,
    FC_SEND  = 2'b01,
    FC_BACKP = 2'b11
  } fc_state_e;

endpackage : mac_flow_pkg

// *** hdl/pause_quanta_timer.sv ***
// Pause timer counting quanta of 512 bit times
`timescale 1ns/1ps

module pause_quanta_timer #(
  parameter int TIME_W = 16
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              load,
  input  wire logic [TIME_W-1:0] loadQuanta,
  input  wire logic              speed100,
  output logic                   active
);

  typedef struct packed {
    logic [TIME_W-1:0]                 quanta;
    logic [mac_flow_pkg::QCYC_W-1:0]   cyc;
  } timer_s;

  timer_s st;
  timer_s next_st;
  logic [mac_flow_pkg::QCYC_W-1:0] perQuantum;

  assign perQuantum = speed100 ? mac_flow_pkg::QUANTUM_CYC_FAST
                               : mac_flow_pkg::QUANTUM_CYC_SLOW;

  // ****************************************
  // Countdown
  // ****************************************
  always_comb
  begin
    next_st = st;
    if (load)
    begin
      next_st.quanta = loadQuanta;
      next_st.cyc    = perQuantum;
    end
    else if (st.quanta != '0)
    begin
      if (st.cyc <= mac_flow_pkg::QCYC_W'(1))
      begin
        next_st.quanta = st.quanta - TIME_W'(1);
        next_st.cyc    = perQuantum;
      end
      else
      begin
        next_st.cyc = st.cyc - mac_flow_pkg::QCYC_W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st <= '0;
    else
      st <= next_st;
  end

  assign active = (st.quanta != '0);

endmodule : pause_quanta_timer

// *** hdl/mac_pause_flow_control.sv ***
// MAC flow control: pause send and receive, backpressure, PHY data holding
`timescale 1ns/1ps

// How it works
// - PHY data register bits 15-0 hold the PHY read value; upper bits read zero.
// - Pause frames carry the pause-time field from flow register bits 31-16.
// - Full duplex: busy stays set from pause request until the frame is sent.
// - Half duplex: busy is set while backpressure is asserted.
// - Pass-control bit sets the filter status for valid pause frames, else clears.
// - Pause frames are acted on only in full duplex with flow control enabled.
// - Enabled: decode frames; valid pause holds transmitter for time times slot.
// - Disabled: no control-frame decoding, flow control inactive; a running hold or pause request still completes.
// - Half duplex: enable bit turns on backpressure instead.
// - No pause frame starts and backpressure ends while the transmitter is disabled; a pause request already made still runs until sent.
// - Every received frame's data is forwarded, whatever the pass-control bit.
// - Promiscuous mode overrides the pass-control bit; the address filter result does not.
// - Software flow control starts from the automatic flow configuration request.
// - Busy clears once the pause frame transmission has completed.
module mac_pause_flow_control #(
  parameter int ADDR_W = 4
) (
  input  wire logic                                 clk,
  input  wire logic                                 rst_n,
  input  wire logic [ADDR_W-1:0]                    regAddr,
  input  wire logic [31:0]                          regWdata,
  input  wire logic                                 regWr,
  input  wire logic                                 regRd,
  output logic [31:0]                               regRdata,
  input  wire logic                                 phyRdValid,
  input  wire logic [mac_flow_pkg::PHY_DATA_W-1:0]  phyRdData,
  output logic [mac_flow_pkg::PHY_DATA_W-1:0]       phyWrData,
  input  wire logic                                 fullDuplex,
  input  wire logic                                 speed100,
  input  wire logic                                 txEnable,
  input  wire logic                                 autoFlowRequest,
  output logic                                      pauseReq,
  output logic [mac_flow_pkg::PAUSE_TIME_W-1:0]     pauseTimeOut,
  input  wire logic                                 pauseSent,
  output logic                                      backpressure,
  output logic                                      flowBusy,
  input  wire logic                                 rxFrameEnd,
  input  wire logic                                 rxPauseValid,
  input  wire logic [mac_flow_pkg::PAUSE_TIME_W-1:0] rxPauseTime,
  input  wire logic                                 rxAddrPass,
  input  wire logic                                 promiscuous,
  output logic                                      rxStatusValid,
  output logic                                      rxPacketFilter,
  output logic                                      rxForward,
  output logic                                      txHold
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [mac_flow_pkg::PHY_DATA_W-1:0]   phyData;
    logic [mac_flow_pkg::PAUSE_TIME_W-1:0] pauseTime;
    logic                                  passCtrl;
    logic                                  flowEn;
    mac_flow_pkg::fc_state_e               fcState;
    logic                                  reqPrev;
    logic [31:0]                           rdData;
    logic                                  statValid;
    logic                                  filterBit;
  } flow_s;

  flow_s st;
  flow_s next_st;
  logic  wrData;
  logic  wrFlow;
  logic  decodeOn;
  logic  pauseLoad;
  logic  reqRise;
  logic  timerActive;

  assign wrData   = regWr && (regAddr == ADDR_W'(mac_flow_pkg::PHY_DATA_IDX));
  assign wrFlow   = regWr && (regAddr == ADDR_W'(mac_flow_pkg::FLOW_IDX));
  assign decodeOn = fullDuplex && st.flowEn;
  assign pauseLoad = rxFrameEnd && rxPauseValid && decodeOn;
  assign reqRise  = autoFlowRequest && !st.reqPrev;

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    next_st = st;
    next_st.reqPrev   = autoFlowRequest;
    next_st.statValid = rxFrameEnd;

    // Host writes, hardware read return wins over them
    if (wrData)
      next_st.phyData = regWdata[mac_flow_pkg::PHY_DATA_W-1:0];
    if (phyRdValid)
      next_st.phyData = phyRdData;
    if (wrFlow)
    begin
      // Busy bit position is not storable; reads return the live busy status there
      next_st.pauseTime = regWdata[31:mac_flow_pkg::FLOW_PT_LSB];
      next_st.passCtrl  = regWdata[mac_flow_pkg::FLOW_PASS_BIT];
      next_st.flowEn    = regWdata[mac_flow_pkg::FLOW_EN_BIT];
    end

    // Register read data, valid the cycle after the strobe
    next_st.rdData = '0;
    if (regRd)
    begin
      if (regAddr == ADDR_W'(mac_flow_pkg::PHY_DATA_IDX))
        next_st.rdData = {16'h0000, st.phyData};
      else if (regAddr == ADDR_W'(mac_flow_pkg::FLOW_IDX))
      begin
        next_st.rdData[31:mac_flow_pkg::FLOW_PT_LSB]   = st.pauseTime;
        next_st.rdData[mac_flow_pkg::FLOW_PASS_BIT]    = st.passCtrl;
        next_st.rdData[mac_flow_pkg::FLOW_EN_BIT]      = st.flowEn;
        next_st.rdData[mac_flow_pkg::FLOW_BUSY_BIT]    = flowBusy;
      end
    end

    // Receive status for every frame
    if (rxFrameEnd)
    begin
      if (promiscuous)
        next_st.filterBit = 1'b1;
      else if (rxPauseValid && decodeOn)
        next_st.filterBit = st.passCtrl;
      else
        next_st.filterBit = rxAddrPass;
    end

    // Pause send and backpressure
    case (st.fcState)
      mac_flow_pkg::FC_IDLE:
      begin
        if (st.flowEn && txEnable)
        begin
          if (fullDuplex && reqRise)
            next_st.fcState = mac_flow_pkg::FC_SEND;
          else if (!fullDuplex && autoFlowRequest)
            next_st.fcState = mac_flow_pkg::FC_BACKP;
        end
      end
      mac_flow_pkg::FC_SEND:
      begin
        if (pauseSent)
          next_st.fcState = mac_flow_pkg::FC_IDLE;
      end
      mac_flow_pkg::FC_BACKP:
      begin
        if (!autoFlowRequest || !txEnable || !st.flowEn || fullDuplex)
          next_st.fcState = mac_flow_pkg::FC_IDLE;
      end
      default:
        next_st.fcState = mac_flow_pkg::FC_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st           <= '0;
      st.phyData   <= mac_flow_pkg::PHY_DATA_RESET[mac_flow_pkg::PHY_DATA_W-1:0];
      st.pauseTime <= mac_flow_pkg::FLOW_RESET[31:mac_flow_pkg::FLOW_PT_LSB];
      st.fcState   <= mac_flow_pkg::FC_IDLE;
    end
    else
      st <= next_st;
  end

  // ****************************************
  // Pause timer
  // ****************************************
  pause_quanta_timer #(
    .TIME_W (mac_flow_pkg::PAUSE_TIME_W)
  ) u_timer (
    .clk        (clk),
    .rst_n      (rst_n),
    .load       (pauseLoad),
    .loadQuanta (rxPauseTime),
    .speed100   (speed100),
    .active     (timerActive)
  );

  // ****************************************
  // Outputs
  // ****************************************
  assign regRdata       = st.rdData;
  assign phyWrData      = st.phyData;
  assign pauseReq       = (st.fcState == mac_flow_pkg::FC_SEND);
  assign pauseTimeOut   = st.pauseTime;
  assign backpressure   = (st.fcState == mac_flow_pkg::FC_BACKP);
  assign flowBusy       = pauseReq || backpressure;
  assign rxStatusValid  = st.statValid;
  assign rxPacketFilter = st.filterBit;
  assign rxForward      = rxFrameEnd;
  assign txHold         = timerActive;

  // ****************************************
  // Assertions
  // ****************************************
  a_phy_read_load: assert property (@(posedge clk) disable iff (!rst_n)
    phyRdValid |=> phyWrData == $past(phyRdData))
    else $error("PHY read value not held");

  a_pause_field: assert property (@(posedge clk) disable iff (!rst_n)
    wrFlow |=> pauseTimeOut == $past(regWdata[31:16]))
    else $error("Pause frame time differs from register");

  a_busy_until_sent: assert property (@(posedge clk) disable iff (!rst_n)
    pauseReq && !pauseSent |=> pauseReq && flowBusy)
    else $error("Busy dropped before pause frame sent");

  a_busy_backp: assert property (@(posedge clk) disable iff (!rst_n)
    backpressure |-> flowBusy && !$past(fullDuplex))
    else $error("Backpressure without busy");

  a_filter_pass: assert property (@(posedge clk) disable iff (!rst_n)
    rxFrameEnd && rxPauseValid && fullDuplex && st.flowEn && !promiscuous
    |=> rxPacketFilter == $past(st.passCtrl))
    else $error("Filter bit does not follow pass control");

  a_hold_start: assert property (@(posedge clk) disable iff (!rst_n)
    rxFrameEnd && rxPauseValid && fullDuplex && st.flowEn && rxPauseTime != 16'h0000
    |=> ##[0:1] txHold)
    else $error("Transmitter not held after pause");

  a_no_decode: assert property (@(posedge clk) disable iff (!rst_n)
    !txHold && !st.flowEn |=> !txHold)
    else $error("Hold started while disabled");

  a_tx_off: assert property (@(posedge clk) disable iff (!rst_n)
    !txEnable && !pauseReq |=> !pauseReq && !backpressure)
    else $error("Flow control started with transmitter off");

  a_busy_clear: assert property (@(posedge clk) disable iff (!rst_n)
    pauseReq && pauseSent |=> !flowBusy)
    else $error("Busy not cleared after pause sent");

  a_promisc: assert property (@(posedge clk) disable iff (!rst_n)
    rxFrameEnd && promiscuous |=> rxPacketFilter && rxStatusValid)
    else $error("Promiscuous did not override filter");

  // ****************************************
  // Assertions on request, status, hold, read and write paths
  // ****************************************
  a_backp_start: assert property (@(posedge clk) disable iff (!rst_n)
    !fullDuplex && st.flowEn && txEnable && autoFlowRequest && !flowBusy
    |=> backpressure)
    else $error("Backpressure not started");

  a_backp_end: assert property (@(posedge clk) disable iff (!rst_n)
    backpressure && !autoFlowRequest |=> !backpressure)
    else $error("Backpressure kept after request dropped");

  a_fd_no_backp: assert property (@(posedge clk) disable iff (!rst_n)
    fullDuplex && !backpressure |=> !backpressure)
    else $error("Backpressure started in full duplex");

  a_pause_start: assert property (@(posedge clk) disable iff (!rst_n)
    fullDuplex && st.flowEn && txEnable && autoFlowRequest && !st.reqPrev && !flowBusy
    |=> pauseReq)
    else $error("Pause request not taken");

  a_no_req_pause: assert property (@(posedge clk) disable iff (!rst_n)
    !pauseReq && !autoFlowRequest |=> !pauseReq)
    else $error("Pause frame without request");

  a_forward_all: assert property (@(posedge clk) disable iff (!rst_n)
    rxFrameEnd |-> rxForward)
    else $error("Received frame not forwarded");

  a_status_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    rxStatusValid == $past(rxFrameEnd))
    else $error("Status strobe out of step with frame end");

  a_filter_clear: assert property (@(posedge clk) disable iff (!rst_n)
    pauseLoad && !promiscuous && !st.passCtrl |=> !rxPacketFilter)
    else $error("Filter bit set with pass control clear");

  a_no_decode_hd: assert property (@(posedge clk) disable iff (!rst_n)
    rxFrameEnd && !promiscuous && !decodeOn |=> rxPacketFilter == $past(rxAddrPass))
    else $error("Pause decoded while not allowed");

  a_filter_holds: assert property (@(posedge clk) disable iff (!rst_n)
    !rxFrameEnd |=> $stable(rxPacketFilter))
    else $error("Filter bit changed without a frame");

  a_hold_reload: assert property (@(posedge clk) disable iff (!rst_n)
    pauseLoad && rxPauseTime == 16'h0000 |=> !txHold)
    else $error("Zero pause time did not end hold");

  a_rd_flow_busy: assert property (@(posedge clk) disable iff (!rst_n)
    regRd && regAddr == ADDR_W'(mac_flow_pkg::FLOW_IDX) |=> regRdata[0] == $past(flowBusy))
    else $error("Busy bit read back wrong");

  a_phy_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
    regRd && regAddr == ADDR_W'(mac_flow_pkg::PHY_DATA_IDX) |=> regRdata[31:16] == 16'h0000)
    else $error("PHY data upper bits not zero");

  a_phy_write: assert property (@(posedge clk) disable iff (!rst_n)
    wrData && !phyRdValid |=> phyWrData == $past(regWdata[15:0]))
    else $error("PHY write value not held");

endmodule : mac_pause_flow_control

// *** sim/link_partner_model.sv ***
// Far-end model that takes pause frames off the cable
`timescale 1ns/1ps

module link_partner_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        pauseReq,
  input  wire logic [15:0] pauseTimeOut,
  input  wire logic [7:0]  sendDelay,
  output logic             pauseSent,
  output logic [15:0]      lastPauseTime
);
  logic [7:0] wait_q;

  // ****************************************
  // Frame on the wire after a set delay
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q        <= 8'h00;
      pauseSent     <= 1'b0;
      lastPauseTime <= 16'h0000;
    end
    else
    begin
      pauseSent <= pauseReq && (wait_q == sendDelay);
      wait_q    <= pauseReq ? wait_q + 8'h01 : 8'h00;
      if (pauseReq && (wait_q == sendDelay))
      begin
        lastPauseTime <= pauseTimeOut;
      end
    end
  end
endmodule : link_partner_model

// *** sim/tb_mac_pause_flow_control.sv ***
// Self-checking bench for the pause and flow-control block
`timescale 1ns/1ps

module tb_mac_pause_flow_control;
  logic clk = 0, rst_n = 0, regWr = 0, regRd = 0, phyRdValid = 0, fullDuplex = 0;
  logic speed100 = 0, txEnable = 0, autoFlowRequest = 0, rxFrameEnd = 0;
  logic rxPauseValid = 0, rxAddrPass = 0, promiscuous = 0;
  logic pauseReq, pauseSent, backpressure, flowBusy, rxStatusValid, rxPacketFilter;
  logic rxForward, txHold, fd, en, ps;
  logic [3:0]  regAddr = 0;
  logic [31:0] regWdata = 0, regRdata, rdv, d;
  logic [15:0] phyRdData = 0, rxPauseTime = 0, phyWrData, pauseTimeOut, lastPt, pt;
  logic [7:0]  sendDelay = 0;
  int fails = 0, nChecks = 0, cyc = 0, i, n, q;

  mac_pause_flow_control i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .phyRdValid(phyRdValid), .phyRdData(phyRdData), .phyWrData(phyWrData),
    .fullDuplex(fullDuplex), .speed100(speed100), .txEnable(txEnable),
    .autoFlowRequest(autoFlowRequest), .pauseReq(pauseReq), .pauseTimeOut(pauseTimeOut),
    .pauseSent(pauseSent), .backpressure(backpressure), .flowBusy(flowBusy),
    .rxFrameEnd(rxFrameEnd), .rxPauseValid(rxPauseValid), .rxPauseTime(rxPauseTime),
    .rxAddrPass(rxAddrPass), .promiscuous(promiscuous), .rxStatusValid(rxStatusValid),
    .rxPacketFilter(rxPacketFilter), .rxForward(rxForward), .txHold(txHold));

  link_partner_model i_partner (.clk(clk), .rst_n(rst_n), .pauseReq(pauseReq),
    .pauseTimeOut(pauseTimeOut), .sendDelay(sendDelay), .pauseSent(pauseSent),
    .lastPauseTime(lastPt));

  // ****************************************
  // Clock, watchdog and helpers
  // ****************************************
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      fails++;
      $display("unexpected at %0t: run hung", $time);
      end_sim();
    end
  end

  task end_sim;
    $display("checks %0d fails %0d", nChecks, fails);
    if (fails == 0 && nChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    nChecks++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  function logic expFilter(input logic pr, v, dec, pass, ap);
    expFilter = pr ? 1'b1 : ((v && dec) ? pass : ap);
  endfunction : expFilter

  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    v = regRdata;
  endtask : rd

  task frame(input logic v, ap, pr, input logic [15:0] t);
    @(posedge clk);
    rxFrameEnd   <= 1'b1;
    rxPauseValid <= v;
    rxAddrPass   <= ap;
    promiscuous  <= pr;
    rxPauseTime  <= t;
    @(negedge clk);
    chk(rxForward, 1, "forward");
    @(posedge clk);
    rxFrameEnd <= 1'b0;
    @(negedge clk);
    chk(rxStatusValid, 1, "status");
    chk(rxPacketFilter, expFilter(pr, v, fd && en, ps, ap), "filter");
  endtask : frame

  task setFlow(input logic pass, enable);
    rd(4'h8, rdv);
    chk(rdv[0], 1'b0, "busy before flow write");
    pt = 16'($urandom_range(1, 65535));
    wr(4'h8, {pt, 13'h0, pass, enable, 1'b0});
    ps = pass;
    en = enable;
  endtask : setFlow

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    void'($urandom(32'h7430));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h7, rdv);
    chk(rdv, mac_flow_pkg::PHY_DATA_RESET, "data reset");
    rd(4'h8, rdv);
    chk(rdv, mac_flow_pkg::FLOW_RESET, "flow reset");
    rd(4'h3, rdv);
    chk(rdv, 32'h0, "unmapped");
    d = $urandom;
    wr(4'h7, d);
    @(negedge clk);
    chk(phyWrData, d[15:0], "phy write value");
    rd(4'h7, rdv);
    chk(rdv, {16'h0, d[15:0]}, "data readback");
    @(posedge clk);
    phyRdValid <= 1'b1;
    phyRdData  <= ~d[15:0];
    @(posedge clk);
    phyRdValid <= 1'b0;
    rd(4'h7, rdv);
    chk(rdv, {16'h0, ~d[15:0]}, "phy read value");
    setFlow(1'b1, 1'b1);
    rd(4'h8, rdv);
    chk(rdv, {pt, 13'h0, 3'b110}, "flow readback");
    @(posedge clk);
    fullDuplex <= 1'b1;
    fd = 1'b1;
    autoFlowRequest <= 1'b1;
    repeat (5) @(negedge clk);
    chk(flowBusy, 0, "tx off");
    @(posedge clk);
    autoFlowRequest <= 1'b0;
    txEnable <= 1'b1;
    for (i = 0; i < 4; i++)
    begin
      setFlow(i[0], 1'b1);
      sendDelay <= 8'($urandom_range(0, 40));
      autoFlowRequest <= 1'b1;
      @(posedge clk);
      autoFlowRequest <= 1'b0;
      chk(pauseTimeOut, pt, "pause time out");
      for (n = 0; n < 60 && !pauseSent; n++)
      begin
        @(negedge clk);
        if (!pauseSent)
          chk({pauseReq, flowBusy}, 2'b11, "busy while sending");
      end
      @(negedge clk);
      chk({pauseReq, flowBusy}, 2'b00, "busy after send");
      chk(lastPt, pt, "pause time on wire");
    end
    @(posedge clk);
    fullDuplex <= 1'b0;
    fd = 1'b0;
    autoFlowRequest <= 1'b1;
    repeat (2) @(negedge clk);
    chk(backpressure, 1, "backpressure on");
    chk(flowBusy, 1, "busy backpressure");
    @(posedge clk);
    autoFlowRequest <= 1'b0;
    repeat (2) @(negedge clk);
    chk(flowBusy, 0, "backpressure off");
    for (i = 0; i < 40; i++)
    begin
      @(posedge clk);
      fullDuplex <= i[1];
      fd = i[1];
      setFlow(1'($urandom), 1'($urandom));
      frame(1'($urandom), 1'($urandom), ($urandom_range(0, 3) == 0), 16'h0);
    end
    @(posedge clk);
    fullDuplex <= 1'b1;
    fd = 1'b1;
    setFlow(1'b0, 1'b0);
    frame(1'b1, 1'b1, 1'b0, 16'h1);
    repeat (3) @(negedge clk);
    chk(txHold, 0, "no hold when disabled");
    setFlow(1'b0, 1'b1);
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      speed100 <= i[0];
      q = i[0] ? mac_flow_pkg::QUANTUM_CYC_FAST : mac_flow_pkg::QUANTUM_CYC_SLOW;
      frame(1'b1, 1'b1, 1'b0, 16'h2);
      for (n = 0; n < 5000 && txHold === 1'b1; n++)
        @(negedge clk);
      chk(n, 2 * q, "hold length");
    end
    end_sim();
  end
endmodule : tb_mac_pause_flow_control
